// ---- design/sere_pkg.sv ----
// Shared constants and types of the serial EEPROM read engine.
// Assumes both link ends and the bench import it whole.
package sere_pkg;
  // ==========================================================
  // Clocks and link timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned SCL_PERIOD_NS = 10_000;
  localparam int unsigned SCL_QTR_CYC   = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int unsigned QTR_MIN_CYC   = 8;
  // ==========================================================
  // Address map and device address byte
  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned ARRAY_BYTES   = 4096;
  localparam logic [3:0]  TYPE_ARRAY    = 4'ha;
  localparam logic [3:0]  TYPE_SERIAL   = 4'hb;
  localparam logic [1:0]  SERIAL_REGION = 2'h2;
  localparam int unsigned SERIAL_OFS_W  = 5;
  localparam int unsigned SERIAL_ID_BYTES = 16;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;
  localparam logic [7:0]  PAD_BYTE      = 8'h00;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  // Arbitrary value, stands in for a factory serial number
  localparam logic [127:0] SERIAL_ID_DEFAULT = 128'h5a3c_96e1_0f24_b7d8_4c61_e29a_7b05_d3f6;
  localparam int unsigned FIFO_DEPTH    = 8;

  typedef enum logic {SERE_CUR_READ, SERE_RAND_READ} sere_kind_t;
endpackage : sere_pkg

// ---- design/sere_link_if.sv ----
// Two-wire link between the read target and the bus controller.
// Open-drain data line with a modelled pull-up; the controller owns the clock.
`timescale 1ns/1ps
`default_nettype none
interface sere_link_if;
  logic scl;
  logic sda;
  logic ctrl_sda_out;
  logic ctrl_sda_oe;
  logic tgt_sda_out;
  logic tgt_sda_oe;

  // Wired-AND with pull-up: any enabled low driver wins
  assign sda = !((ctrl_sda_oe && !ctrl_sda_out) || (tgt_sda_oe && !tgt_sda_out));

  modport target (input scl, input sda, output tgt_sda_out, output tgt_sda_oe);
  modport ctrl   (output scl, output ctrl_sda_out, output ctrl_sda_oe, input sda);
endinterface : sere_link_if
`default_nettype wire

// ---- design/sere_target.sv ----
// Read side of a two-wire serial EEPROM target: array, serial region, pointer.
// Assumes the link clock is slow against clk_in (a quarter SCL period >= 8 clocks).
`timescale 1ns/1ps
`default_nettype none
module sere_target
  import sere_pkg::*;
#(
  parameter logic [127:0] SERIAL_ID = SERIAL_ID_DEFAULT
) (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              hw_select_pin_2_in,
  input  wire logic              hw_select_pin_1_in,
  input  wire logic              hw_select_pin_0_in,
  input  wire logic              load_en_in,
  input  wire logic [ADDR_W-1:0] load_addr_in,
  input  wire logic [7:0]        load_data_in,
  sere_link_if.target            link
);
  // ==========================================================
  // State
  typedef enum logic [3:0] {
    T_IDLE, T_DEV, T_DEV_ACK, T_WA_HI, T_HI_ACK, T_WA_LO, T_LO_ACK,
    T_TX, T_TX_ACK, T_IGNORE
  } sere_tstate_t;

  typedef struct packed {
    sere_tstate_t      st;
    logic [2:0]        scl_s;
    logic [2:0]        sda_s;
    logic [5:0]        sel_s;
    logic [3:0]        bits;
    logic [7:0]        sh;
    logic [ADDR_W-1:0] ptr;
    logic [3:0]        wa_hi;
    logic              serial;
    logic              ack;
    logic              oe;
    logic              sda_o;
  } sere_tgt_t;

  sere_tgt_t q;
  sere_tgt_t n;

  // Preload port stands in for factory programming; writes are out of scope
  logic [7:0] mem_q [ARRAY_BYTES] = '{default: ERASED_BYTE};

  initial begin
    if (SERIAL_ID_BYTES * 2 != (1 << SERIAL_OFS_W)) begin
      $error("serial region size mismatch");
    end
  end

  always_ff @(posedge clk_in) begin
    if (load_en_in) begin
      mem_q[load_addr_in] <= load_data_in;
    end
  end

  // ==========================================================
  // Byte source and pointer step
  function automatic logic [7:0] rd_byte(input logic [ADDR_W-1:0] p, input logic ser);
    logic [3:0] idx;
    idx = p[3:0];
    if (!ser) begin
      rd_byte = mem_q[p];
    end else if (p[ADDR_W-1 -: 2] != SERIAL_REGION) begin
      rd_byte = ERASED_BYTE;
    end else if (!p[SERIAL_OFS_W-1]) begin
      rd_byte = SERIAL_ID[(SERIAL_ID_BYTES - 1 - idx) * 8 +: 8];
    end else begin
      rd_byte = PAD_BYTE;
    end
  endfunction : rd_byte

  function automatic logic [ADDR_W-1:0] next_ptr(input logic [ADDR_W-1:0] p, input logic ser);
    if (ser) begin
      next_ptr = {p[ADDR_W-1:SERIAL_OFS_W], p[SERIAL_OFS_W-1:0] + 5'h01};
    end else begin
      next_ptr = p + 12'h001;
    end
  endfunction : next_ptr

  // ==========================================================
  // Link engine
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic       load;
  logic [7:0] cur;
  logic       match;

  always_comb begin
    n       = q;
    n.sda_o = 1'b0;
    n.scl_s = {q.scl_s[1:0], link.scl};
    n.sda_s = {q.sda_s[1:0], link.sda};
    // Select straps are pins: two flops before the compare
    n.sel_s = {q.sel_s[2:0], hw_select_pin_2_in, hw_select_pin_1_in, hw_select_pin_0_in};
    rise    = q.scl_s[1] && !q.scl_s[2];
    fall    = !q.scl_s[1] && q.scl_s[2];
    start   = q.scl_s[1] && q.scl_s[2] && !q.sda_s[1] && q.sda_s[2];
    stop    = q.scl_s[1] && q.scl_s[2] && q.sda_s[1] && !q.sda_s[2];
    cur     = rd_byte(q.ptr, q.serial);
    load    = 1'b0;
    match   = (q.sh[7:4] == TYPE_ARRAY || q.sh[7:4] == TYPE_SERIAL) &&
              (q.sh[3:1] == q.sel_s[5:3]);

    if (start) begin
      n.st   = T_DEV;
      n.bits = 4'h0;
      n.oe   = 1'b0;
    end else if (stop) begin
      n.st = T_IDLE;
      n.oe = 1'b0;
    end else begin
      case (q.st)
        T_DEV, T_WA_HI, T_WA_LO: begin
          if (rise) begin
            n.sh   = {q.sh[6:0], q.sda_s[1]};
            n.bits = q.bits + 4'h1;
          end else if (fall && q.bits == BYTE_BITS) begin
            n.oe = 1'b1;
            if (q.st == T_DEV) begin
              if (match) begin
                n.serial = (q.sh[7:4] == TYPE_SERIAL);
                n.ack    = q.sh[0];
                n.st     = T_DEV_ACK;
              end else begin
                n.oe = 1'b0;
                n.st = T_IGNORE;
              end
            end else if (q.st == T_WA_HI) begin
              n.wa_hi = q.sh[3:0];
              n.st    = T_HI_ACK;
            end else begin
              n.ptr = {q.wa_hi, q.sh};
              n.st  = T_LO_ACK;
            end
          end
        end
        T_DEV_ACK, T_HI_ACK, T_LO_ACK: begin
          if (fall) begin
            n.oe   = 1'b0;
            n.bits = 4'h0;
            if (q.st == T_DEV_ACK) begin
              if (q.ack) begin
                load = 1'b1;
              end else begin
                n.st = T_WA_HI;
              end
            end else if (q.st == T_HI_ACK) begin
              n.st = T_WA_LO;
            end else begin
              // Data bytes of a write are not served; wait for a new Start
              n.st = T_IGNORE;
            end
          end
        end
        T_TX: begin
          if (fall) begin
            if (q.bits == BYTE_BITS - 4'h1) begin
              n.oe = 1'b0;
              n.st = T_TX_ACK;
            end else begin
              n.sh   = {q.sh[6:0], 1'b0};
              n.oe   = !q.sh[6];
              n.bits = q.bits + 4'h1;
            end
          end
        end
        T_TX_ACK: begin
          if (rise) begin
            n.ack = !q.sda_s[1];
          end else if (fall) begin
            if (q.ack) begin
              load = 1'b1;
            end else begin
              n.st = T_IDLE;
            end
          end
        end
        default: begin
          n.oe = 1'b0;
        end
      endcase
    end

    // Fetch at the pointer, then step it past the byte just taken
    if (load) begin
      n.sh   = cur;
      n.oe   = !cur[7];
      n.ptr  = next_ptr(q.ptr, q.serial);
      n.bits = 4'h0;
      n.st   = T_TX;
    end
  end

  // Pointer is deliberately kept through Stop and Start
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q       <= '0;
      q.st    <= T_IDLE;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
    end else begin
      q <= n;
    end
  end

  assign link.tgt_sda_oe  = q.oe;
  assign link.tgt_sda_out = q.sda_o;
endmodule : sere_target
`default_nettype wire

// ---- design/sere_ctrl.sv ----
// Bus controller end: issues current-address and random reads and buffers bytes.
// Assumes the target sits on the same link and its reply lags SCL by a few clocks.
`timescale 1ns/1ps
`default_nettype none
module sere_fifo
  import sere_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0]   cnt;
    logic          full;
    logic          nempty;
  } sere_fifo_t;

  sere_fifo_t     q;
  sere_fifo_t     n;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic           push;
  logic           pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fifo depth must be a power of two");
    end
  end

  always_comb begin
    n    = q;
    push = in_valid_in && !q.full;
    pop  = out_ready_in && q.nempty;
    if (push) begin
      n.wr = q.wr + 1'b1;
    end
    if (pop) begin
      n.rd = q.rd + 1'b1;
    end
    n.cnt    = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    n.full   = (n.cnt == (AW + 1)'(DEPTH));
    n.nempty = (n.cnt != '0);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
    if (push) begin
      mem_q[q.wr] <= in_data_in;
    end
  end

  assign in_ready_out  = !q.full;
  assign out_valid_out = q.nempty;
  assign out_data_out  = mem_q[q.rd];
endmodule : sere_fifo

module sere_ctrl
  import sere_pkg::*;
#(
  parameter int unsigned QTR_CYC = SCL_QTR_CYC
) (
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              cmd_valid_in,
  output logic                   cmd_ready_out,
  input  wire sere_kind_t        cmd_kind_in,
  input  wire logic              cmd_serial_in,
  input  wire logic [2:0]        cmd_sel_in,
  input  wire logic [ADDR_W-1:0] cmd_addr_in,
  input  wire logic [7:0]        cmd_count_in,
  output logic                   rd_valid_out,
  input  wire logic              rd_ready_in,
  output logic [7:0]             rd_data_out,
  output logic                   done_out,
  output logic                   nack_err_out,
  sere_link_if.ctrl              link
);
  // ==========================================================
  // State
  typedef enum logic [2:0] {M_IDLE, M_START, M_SEND, M_RECV, M_STOP} sere_mstate_t;
  typedef enum logic [2:0] {P_DEVW, P_HI, P_LO, P_DEVR, P_DATA} sere_phase_t;

  typedef struct packed {
    sere_mstate_t      st;
    sere_phase_t       ph;
    logic [1:0]        qtr;
    logic [15:0]       cnt;
    logic [3:0]        bits;
    logic [7:0]        sh;
    logic [7:0]        rem;
    logic              serial;
    logic [2:0]        sel;
    logic [ADDR_W-1:0] addr;
    logic [1:0]        sda_s;
    logic              scl;
    logic              oe;
    logic              sda_o;
    logic              ready;
    logic              done;
    logic              err;
    logic              push;
  } sere_ctrl_t;

  sere_ctrl_t q;
  sere_ctrl_t n;
  logic       fifo_ready;

  initial begin
    if (QTR_CYC < QTR_MIN_CYC || QTR_CYC > 65535) begin
      $error("quarter period out of range");
    end
  end

  function automatic logic [7:0] dev_byte(input logic ser, input logic [2:0] sel,
                                          input logic rd);
    dev_byte = {ser ? TYPE_SERIAL : TYPE_ARRAY, sel, rd};
  endfunction : dev_byte

  // ==========================================================
  // Symbol sequencer: four quarter ticks per bit, START and STOP
  logic tick;

  always_comb begin
    n       = q;
    n.sda_o = 1'b0;
    n.done  = 1'b0;
    n.push  = 1'b0;
    n.sda_s = {q.sda_s[0], link.sda};
    tick    = (q.cnt == 16'(QTR_CYC - 1));
    n.cnt   = tick ? 16'h0000 : q.cnt + 16'h0001;
    if (q.st == M_IDLE) begin
      if (cmd_valid_in && q.ready) begin
        n.ready  = 1'b0;
        n.err    = 1'b0;
        n.serial = cmd_serial_in;
        n.sel    = cmd_sel_in;
        n.addr   = cmd_addr_in;
        n.rem    = cmd_count_in;
        n.ph     = (cmd_kind_in == SERE_RAND_READ) ? P_DEVW : P_DEVR;
        n.st     = M_START;
        n.qtr    = 2'h0;
        n.cnt    = 16'h0000;
      end
    end else if (tick) begin
      n.qtr = q.qtr + 2'h1;
      case (q.st)
        M_START: begin
          if (q.qtr == 2'h0) begin
            n.scl = 1'b0;
            n.oe  = 1'b0;
          end else if (q.qtr == 2'h1) begin
            n.scl = 1'b1;
          end else if (q.qtr == 2'h2) begin
            n.oe = 1'b1;
          end else begin
            n.st   = M_SEND;
            n.bits = 4'h0;
            n.sh   = dev_byte(q.serial, q.sel, q.ph != P_DEVW);
          end
        end
        M_SEND: begin
          if (q.qtr == 2'h0) begin
            n.scl = 1'b0;
            n.oe  = (q.bits != BYTE_BITS) && !q.sh[7];
          end else if (q.qtr == 2'h2) begin
            n.scl = 1'b1;
          end else if (q.qtr == 2'h3) begin
            n.bits = q.bits + 4'h1;
            n.sh   = {q.sh[6:0], 1'b0};
            if (q.bits == BYTE_BITS) begin
              n.bits = 4'h0;
              if (q.sda_s[1]) begin
                n.err = 1'b1;
                n.st  = M_STOP;
              end else if (q.ph == P_DEVW) begin
                n.ph = P_HI;
                n.sh = {4'h0, q.addr[ADDR_W-1:8]};
              end else if (q.ph == P_HI) begin
                n.ph = P_LO;
                n.sh = q.addr[7:0];
              end else if (q.ph == P_LO) begin
                n.ph = P_DEVR;
                n.st = M_START;
              end else begin
                n.ph = P_DATA;
                n.st = M_RECV;
              end
            end
          end
        end
        M_RECV: begin
          if (q.qtr == 2'h0) begin
            n.scl = 1'b0;
            n.oe  = (q.bits == BYTE_BITS) && (q.rem != 8'h00);
            // Hold SCL low until the buffer can take a whole byte
            if (q.bits == 4'h0 && !fifo_ready) begin
              n.qtr = q.qtr;
            end
          end else if (q.qtr == 2'h2) begin
            n.scl = 1'b1;
          end else if (q.qtr == 2'h3) begin
            if (q.bits != BYTE_BITS) begin
              n.sh   = {q.sh[6:0], q.sda_s[1]};
              n.bits = q.bits + 4'h1;
              n.push = (q.bits == BYTE_BITS - 4'h1);
            end else if (q.rem != 8'h00) begin
              n.rem  = q.rem - 8'h01;
              n.bits = 4'h0;
            end else begin
              n.st = M_STOP;
            end
          end
        end
        M_STOP: begin
          if (q.qtr == 2'h0) begin
            n.scl = 1'b0;
            n.oe  = 1'b1;
          end else if (q.qtr == 2'h1) begin
            n.scl = 1'b1;
          end else if (q.qtr == 2'h2) begin
            n.oe = 1'b0;
          end else begin
            n.st    = M_IDLE;
            n.done  = 1'b1;
            n.ready = 1'b1;
          end
        end
        default: begin
          n.st = M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q       <= '0;
      q.st    <= M_IDLE;
      q.ph    <= P_DEVW;
      q.scl   <= 1'b1;
      q.sda_s <= 2'h3;
      q.ready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  sere_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (q.push),
    .in_ready_out  (fifo_ready),
    .in_data_in    (q.sh),
    .out_valid_out (rd_valid_out),
    .out_ready_in  (rd_ready_in),
    .out_data_out  (rd_data_out)
  );

  assign cmd_ready_out     = q.ready;
  assign done_out          = q.done;
  assign nack_err_out      = q.err;
  assign link.scl          = q.scl;
  assign link.ctrl_sda_oe  = q.oe;
  assign link.ctrl_sda_out = q.sda_o;
endmodule : sere_ctrl
`default_nettype wire

// ---- dv/sere_link_sva.sv ----
// Concurrent checks on the two-wire link between controller and target.
// Assumes the link signals arrive as plain inputs, all in the clk_in domain.
`timescale 1ns/1ps
`default_nettype none
module sere_link_sva
  import sere_pkg::*;
#(
  parameter logic [2:0] SEL = 3'h0
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic ctrl_sda_out,
  input wire logic ctrl_sda_oe,
  input wire logic tgt_sda_out,
  input wire logic tgt_sda_oe
);
  // ==========================================================
  // Frame tracking
  logic       scl_q;
  logic       sda_q;
  logic       rw_q;
  logic       ended_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q;
  wire logic  rise = scl && !scl_q;
  wire logic  st   = scl && scl_q && sda_q && !sda;
  wire logic  sp   = scl && scl_q && !sda_q && sda;
  wire logic  slot = rise && (bit_q == 4'h8);
  wire logic  hit  = (sh_q[7:5] == 3'h5) && (sh_q[3:1] == SEL);

  always_ff @(posedge clk_in) begin
    scl_q <= scl;
    sda_q <= sda;
    if (slot && byte_q == 3'h0) begin
      rw_q <= sh_q[0];
    end
    if (reset_in || st || sp) begin
      bit_q   <= 4'h0;
      byte_q  <= 3'h0;
      ended_q <= 1'b0;
    end else if (slot) begin
      bit_q   <= 4'h0;
      byte_q  <= byte_q + 3'(byte_q != 3'h7);
      ended_q <= ended_q || (rw_q && byte_q != 3'h0 && sda);
    end else if (rise) begin
      bit_q <= bit_q + 4'h1;
      sh_q  <= {sh_q[6:0], sda};
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence s_addr_hit;  slot && byte_q == 3'h0 && hit; endsequence
  sequence s_read_nack; slot && rw_q && byte_q != 3'h0 && sda; endsequence
  sequence s_stop;      ##[1:100] sp; endsequence

  property p_sel_ack;    s_addr_hit |-> !sda; endproperty
  property p_sel_nack;   slot && byte_q == 3'h0 && !hit |-> sda; endproperty
  property p_word_ack;   slot && !rw_q && byte_q inside {3'h1, 3'h2} |-> !sda; endproperty
  property p_no_data;    slot && byte_q == 3'h3 |-> rw_q; endproperty
  property p_quiet;
    rise && rw_q && !ended_q && byte_q != 3'h0 && bit_q != 4'h8 |-> !ctrl_sda_oe;
  endproperty
  property p_release;    ended_q |-> !tgt_sda_oe; endproperty
  property p_stop;       s_read_nack |-> s_stop; endproperty
  property p_change_low; $changed(tgt_sda_oe) |-> !scl; endproperty

  a_sel_ack:    assert property (p_sel_ack) else $error("address byte not acked");
  a_sel_nack:   assert property (p_sel_nack) else $error("foreign address acked");
  a_word_ack:   assert property (p_word_ack) else $error("word byte not acked");
  a_no_data:    assert property (p_no_data) else $error("data byte in dummy write");
  a_quiet:      assert property (p_quiet) else $error("master drives read bit");
  a_release:    assert property (p_release) else $error("target drives after nack");
  a_stop:       assert property (p_stop) else $error("no stop after nack");
  a_change_low: assert property (p_change_low) else $error("data changed, clock high");
endmodule : sere_link_sva
`default_nettype wire

// ---- dv/serial_eeprom_read_engine_tb_top.sv ----
// Bench: controller and target joined on one link, bytes checked against a model.
// Assumes sere_pkg, both design ends and the link checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_read_engine_tb_top;
  import sere_pkg::*;
  localparam logic [2:0] SEL = 3'h5;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic        ld_en = 1'b0;
  logic [11:0] ld_addr = 12'h000;
  logic [7:0]  ld_data = 8'h00;
  logic        cmd_valid = 1'b0;
  sere_kind_t  cmd_kind = SERE_CUR_READ;
  logic        cmd_serial = 1'b0;
  logic [2:0]  cmd_sel = 3'h0;
  logic [11:0] cmd_addr = 12'h000;
  logic [7:0]  cmd_count = 8'h00;
  logic        rd_ready = 1'b0;
  wire logic   cmd_ready, rd_valid, done, nack_err;
  wire logic [7:0] rd_data;
  int          failures = 0;
  int          samples_checked = 0;
  logic [7:0]  mem [ARRAY_BYTES];
  logic [7:0]  expq [$];
  logic [11:0] ptr = 12'h000;
  logic [31:0] seed = 32'h0001_2a3f;
  logic [31:0] r;
  bit          stall = 1'b0;
  logic [11:0] pl [6] = '{12'hffe, 12'hfff, 12'h000, 12'h001, 12'h002, 12'h123};

  sere_link_if i_sere_link_if ();
  sere_target i_sere_target (.clk_in(clk_in), .reset_in(reset_in),
    .hw_select_pin_2_in(SEL[2]), .hw_select_pin_1_in(SEL[1]), .hw_select_pin_0_in(SEL[0]),
    .load_en_in(ld_en), .load_addr_in(ld_addr), .load_data_in(ld_data),
    .link(i_sere_link_if));
  sere_ctrl #(.QTR_CYC(8)) i_sere_ctrl (.clk_in(clk_in), .reset_in(reset_in),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_kind_in(cmd_kind),
    .cmd_serial_in(cmd_serial), .cmd_sel_in(cmd_sel), .cmd_addr_in(cmd_addr),
    .cmd_count_in(cmd_count), .rd_valid_out(rd_valid), .rd_ready_in(rd_ready),
    .rd_data_out(rd_data), .done_out(done), .nack_err_out(nack_err),
    .link(i_sere_link_if));
  sere_link_sva #(.SEL(SEL)) i_sere_link_sva (.clk_in(clk_in), .reset_in(reset_in),
    .scl(i_sere_link_if.scl), .sda(i_sere_link_if.sda),
    .ctrl_sda_out(i_sere_link_if.ctrl_sda_out), .ctrl_sda_oe(i_sere_link_if.ctrl_sda_oe),
    .tgt_sda_out(i_sere_link_if.tgt_sda_out), .tgt_sda_oe(i_sere_link_if.tgt_sda_oe));

  always #(CLK_PERIOD_NS / 2) clk_in = !clk_in;

  // ==========================================================
  // Model and helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [7:0] model_byte(bit ser);
    if (!ser) return mem[ptr];
    if (ptr[11:10] != SERIAL_REGION) return ERASED_BYTE;
    return ptr[4] ? PAD_BYTE : SERIAL_ID_DEFAULT[127 - 8 * ptr[3:0] -: 8];
  endfunction : model_byte

  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic close_out();
    if (failures == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  task automatic run(sere_kind_t k, bit ser, logic [2:0] sel, logic [11:0] a,
                     logic [7:0] n, bit exp_err);
    int i;
    if (k == SERE_RAND_READ && sel == SEL) ptr = a;
    for (i = 0; sel == SEL && i <= n; i++) begin
      expq.push_back(model_byte(ser));
      ptr = ser ? {ptr[11:5], ptr[4:0] + 5'h01} : ptr + 12'h001;
    end
    @(posedge clk_in);
    cmd_valid  <= 1'b1;
    cmd_kind   <= k;
    cmd_serial <= ser;
    cmd_sel    <= sel;
    cmd_addr   <= a;
    cmd_count  <= n;
    @(posedge clk_in);
    while (cmd_ready !== 1'b1) @(posedge clk_in);
    cmd_valid <= 1'b0;
    for (i = 0; i < 40000 && done !== 1'b1; i++) @(posedge clk_in);
    cmp("done_out", 8'h01, {7'h00, done});
    stall = 1'b0;
    for (i = 0; i < 2000 && expq.size() != 0; i++) @(posedge clk_in);
    cmp("bytes_missing", 8'h00, 8'(expq.size()));
    cmp("nack_err_out", {7'h00, exp_err}, {7'h00, nack_err});
  endtask : run

  // Random ready drops pace the reader; the held stall fills the buffer and forces clock stretching
  always @(posedge clk_in) begin
    if (rd_valid === 1'b1 && rd_ready) begin
      if (expq.size() == 0) cmp("extra_byte", 8'h00, 8'h01);
      else cmp("rd_data_out", expq.pop_front(), rd_data);
    end
    r = rnd();
    rd_ready <= stall ? 1'b0 : r[0];
  end

  // ==========================================================
  // Scenarios
  initial begin
    for (int i = 0; i < ARRAY_BYTES; i++) mem[i] = ERASED_BYTE;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    foreach (pl[i]) begin
      r = rnd();
      @(posedge clk_in);
      ld_en   <= 1'b1;
      ld_addr <= pl[i];
      ld_data <= r[7:0];
      mem[pl[i]] = r[7:0];
    end
    @(posedge clk_in);
    ld_en <= 1'b0;
    run(SERE_CUR_READ, 1'b0, SEL, 12'h000, 8'h01, 1'b0);
    run(SERE_RAND_READ, 1'b0, SEL, 12'hffe, 8'h03, 1'b0);
    run(SERE_CUR_READ, 1'b0, SEL, 12'h000, 8'h00, 1'b0);
    fork
      run(SERE_RAND_READ, 1'b1, SEL, 12'h800, 8'h20, 1'b0);
      begin
        stall = 1'b1;
        repeat (5000) @(posedge clk_in);
        stall = 1'b0;
      end
    join
    run(SERE_RAND_READ, 1'b1, SEL, 12'h40c, 8'h00, 1'b0);
    run(SERE_RAND_READ, 1'b0, SEL ^ 3'h1, 12'h123, 8'h00, 1'b1);
    run(SERE_RAND_READ, 1'b0, SEL, 12'h123, 8'h01, 1'b0);
    repeat (3) begin
      r = rnd();
      run(SERE_RAND_READ, 1'b0, SEL, r[11:0], {6'h00, r[13:12]}, 1'b0);
    end
    close_out();
  end

  initial begin
    repeat (100000) @(posedge clk_in);
    failures++;
    close_out();
  end
endmodule : serial_eeprom_read_engine_tb_top
`default_nettype wire
